// *** twr_receiver.sv ***
// Purpose: Word receiver, distribution, mode and abort control
// Assumes: Serial bits synchronous to pclk, start bit stripped upstream
// Notes: Software processes each distributed word, then writes done
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1: Remote sends 21-bit words at most 60 per second, 1260 bit/s.
// RL2: Outgoing words to the computer are 12 bits wide.
// RL3: Serial data shifts into the 20-bit input register one bit at a time.
// RL4: A full 20-bit word signals the control sequencer to start.
// RL5: The sequencer moves each word in parallel into the distribution register.
// RL6: Word or fields route from distribution register to internal or external.
// RL7: A 4-bit mode register steers processing of incoming words; here mode_reg is only loaded and read back over APB, it steers nothing.
// RL8: Mode selects operating mode and write or erase condition.
// RL9: Parity error enters abort and lights the error indicator.
// RL10: Error indicator is on exactly while abort is active.
// RL11: Abort holds until a qualifying word or the error switch.
// RL12: Error switch clears abort without other initialisation.
// RL13: Clear switch initialises, clears abort, requests full erase.
// RL14: Clear switch turns the projector lamp off.
// RL15: Auto reset within 3 s initialises everything, lamp off.
// RL16: Bit 0 carries odd parity over the word.
// RL17: Bit 19 is zero for control words, one for data words.
// RL18: Modem strips the start bit; only 20 bits arrive.
// RL19: On parity error the 7-bit word count is sent back.
// RL20: No new word moves until the previous one is processed.
// RL21: In abort every word except the clearing word is dropped.
module twr_receiver #(
    parameter longint AUTO_CYCLES = twr_pkg::AUTO_RESET_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic error_switch,
    input wire logic clear_switch,
    output logic error_lamp,
    output logic lamp_on,
    output logic erase_req,
    output logic ext_inhibit,
    output twr_pkg::twr_word_type ext_word,
    output twr_pkg::twr_tx_type tx_word
);
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    twr_pkg::twr_word_type full_word;
    twr_pkg::twr_word_type held_reg;
    logic [twr_pkg::WORD_W-1:0] dist_reg;
    logic [twr_pkg::MODE_W-1:0] mode_reg;
    logic [twr_pkg::COUNT_W-1:0] received_word_counter;
    logic abort_reg;
    logic auto_reset;
    logic init;
    logic wr;
    logic rd;
    logic sw_done;
    logic sw_err;
    logic parity_ok;
    logic is_ctrl;
    logic [2:0] dest;
    logic is_clearing;

    typedef enum {TWR_IDLE, TWR_BUSY} twr_seq_type;
    twr_seq_type state_reg;

    function automatic logic odd_ok(input logic [twr_pkg::WORD_W-1:0] w);
        return ^w; // RL16
    endfunction : odd_ok

    twr_shift_in u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .sync_clear(init),
        .bit_valid(rx_bit_valid), // RL18
        .bit_data(rx_bit),
        .word_out(full_word)
    );

    twr_auto_reset #(.CYCLES(AUTO_CYCLES)) u_auto (
        .pclk(pclk),
        .presetn(presetn),
        .auto_reset(auto_reset)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign sw_done = wr && paddr[7:0] == twr_pkg::OFS_CTRL && pwdata[twr_pkg::CTRL_DONE];
    assign sw_err = wr && paddr[7:0] == twr_pkg::OFS_CTRL && pwdata[twr_pkg::CTRL_ERR_SW];
    assign init = auto_reset || clear_switch
        || (wr && paddr[7:0] == twr_pkg::OFS_CTRL && pwdata[twr_pkg::CTRL_CLR_SW]); // RL13 RL15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr[7:0])
                twr_pkg::OFS_STATUS: prdata <= {29'h0, state_reg == TWR_BUSY, held_reg.valid, abort_reg};
                twr_pkg::OFS_DIST: prdata <= {12'h0, dist_reg}; // RL6
                twr_pkg::OFS_MODE: prdata <= {28'h0, mode_reg};
                twr_pkg::OFS_COUNT: prdata <= {25'h0, received_word_counter};
                twr_pkg::OFS_TXWORD: prdata <= {20'h0, tx_word.data};
                default: prdata <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // Word classification
    // ----------------------------------------
    assign parity_ok = odd_ok(held_reg.data);
    assign is_ctrl = !held_reg.data[twr_pkg::TYPE_BIT]; // RL17
    assign dest = held_reg.data[twr_pkg::DEST_LSB +: 3];
    assign is_clearing = is_ctrl && dest == twr_pkg::DEST_LOAD_MODE;

    // Holds one word so the shifter keeps running while the sequencer is busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= '0;
        end else if (init) begin
            held_reg <= '0;
        end else if (full_word.valid) begin
            held_reg <= full_word;
        end else if (state_reg == TWR_IDLE) begin
            held_reg.valid <= 1'b0; // RL20
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TWR_IDLE;
            dist_reg <= '0;
        end else if (init) begin
            state_reg <= TWR_IDLE;
        end else begin
            case (state_reg)
                TWR_IDLE: begin
                    if (held_reg.valid && parity_ok && (!abort_reg || is_clearing)) begin // RL21
                        dist_reg <= held_reg.data; // RL5
                        state_reg <= TWR_BUSY; // RL20
                    end
                end
                TWR_BUSY: begin
                    if (sw_done) begin
                        state_reg <= TWR_IDLE;
                    end
                end
                default: state_reg <= TWR_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Abort, mode, counter, outputs
    // ----------------------------------------
    logic accept;
    logic perr;
    assign accept = state_reg == TWR_IDLE && held_reg.valid && parity_ok && (!abort_reg || is_clearing);
    assign perr = state_reg == TWR_IDLE && held_reg.valid && !parity_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_reg <= 1'b0;
        end else if (perr) begin
            abort_reg <= 1'b1; // RL9
        end else if (init || error_switch || sw_err) begin
            abort_reg <= 1'b0; // RL12 RL13
        end else if (accept && is_clearing) begin
            abort_reg <= 1'b0; // RL11
        end
    end
    assign error_lamp = abort_reg; // RL10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= twr_pkg::MODE_RESET;
            received_word_counter <= twr_pkg::COUNT_RESET;
            ext_inhibit <= 1'b0;
            erase_req <= 1'b0;
        end else begin
            erase_req <= init; // RL13
            if (init) begin
                mode_reg <= twr_pkg::MODE_RESET;
                received_word_counter <= twr_pkg::COUNT_RESET;
                ext_inhibit <= 1'b0;
            end else if (accept && is_ctrl && dest == twr_pkg::DEST_LOAD_MODE) begin
                if (!abort_reg) begin
                    // Screen command sits below the mode field
                    mode_reg <= held_reg.data[twr_pkg::MODE_LSB +: twr_pkg::MODE_W]; // RL7 RL8
                    ext_inhibit <= held_reg.data[twr_pkg::EXT_INH_BIT];
                    if (held_reg.data[twr_pkg::SCREEN_BIT]) begin // RL8
                        erase_req <= 1'b1;
                    end
                end
                if (held_reg.data[twr_pkg::COUNT_LD_BIT]) begin
                    received_word_counter <= held_reg.data[twr_pkg::COUNT_LSB +: twr_pkg::COUNT_W];
                end else begin
                    received_word_counter <= received_word_counter + 1'b1;
                end
            end else if (accept && !(is_ctrl && dest == twr_pkg::DEST_NOP)) begin
                received_word_counter <= received_word_counter + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_on <= 1'b0;
            ext_word <= '0;
            tx_word <= '0;
        end else begin
            ext_word.valid <= 1'b0;
            tx_word.valid <= 1'b0;
            if (init) begin
                lamp_on <= 1'b0; // RL14 RL15
            end else if (accept && is_ctrl && dest == twr_pkg::DEST_SLIDE) begin
                lamp_on <= held_reg.data[twr_pkg::LAMP_BIT];
            end
            if (accept && !ext_inhibit) begin
                ext_word <= held_reg; // RL6
            end
            if (perr) begin
                tx_word.valid <= 1'b1;
                tx_word.data <= {5'h0, received_word_counter}; // RL19 RL2
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_lamp_abort;
        @(posedge pclk) disable iff (!presetn)
        $changed(error_lamp) |-> (error_lamp ? $past(perr)
            : $past(init || error_switch || sw_err || (accept && is_clearing)));
    endproperty
    a_lamp_abort: assert property (p_lamp_abort) else $error("lamp differs from abort"); // RL10

    property p_perr_abort;
        @(posedge pclk) disable iff (!presetn)
        perr |=> abort_reg && tx_word.valid;
    endproperty
    a_perr_abort: assert property (p_perr_abort) else $error("parity error not aborted"); // RL9

    property p_tx_count;
        @(posedge pclk) disable iff (!presetn)
        perr |=> tx_word.data[6:0] == $past(received_word_counter);
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("wrong count sent"); // RL19

    property p_errsw;
        @(posedge pclk) disable iff (!presetn)
        error_switch && !perr |=> !abort_reg;
    endproperty
    a_errsw: assert property (p_errsw) else $error("error switch did not clear"); // RL12

    property p_clear_lamp;
        @(posedge pclk) disable iff (!presetn)
        clear_switch |=> !lamp_on && erase_req;
    endproperty
    a_clear_lamp: assert property (p_clear_lamp) else $error("clear did not reset lamp"); // RL14

    property p_busy_hold;
        @(posedge pclk) disable iff (!presetn)
        state_reg == TWR_BUSY && !sw_done && !init |=> $stable(dist_reg);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("word moved while busy"); // RL20

    property p_abort_drop;
        @(posedge pclk) disable iff (!presetn)
        abort_reg && state_reg == TWR_IDLE && !is_clearing && !init |=> $stable(mode_reg);
    endproperty
    a_abort_drop: assert property (p_abort_drop) else $error("word taken in abort"); // RL21

    property p_move;
        @(posedge pclk) disable iff (!presetn)
        accept && !init |=> dist_reg == $past(held_reg.data) && state_reg == TWR_BUSY;
    endproperty
    a_move: assert property (p_move) else $error("word not distributed"); // RL5
endmodule : twr_receiver
`default_nettype wire

// *** twr_pkg.sv ***
// Purpose: Shared constants and carriers for the terminal word receiver
// Assumes: 100 MHz pclk
// Notes: Register map reached over APB
package twr_pkg;

    // ----------------------------------------
    // Word format
    // ----------------------------------------
    localparam int WORD_W = 20;
    localparam int PARITY_BIT = 0;
    localparam int TYPE_BIT = 19;
    localparam int DEST_LSB = 16;
    localparam int MODE_W = 4;
    localparam int COUNT_W = 7;
    localparam int OUT_W = 12;
    localparam int COUNT_LD_BIT = 14;
    localparam int COUNT_LSB = 7;
    localparam int EXT_INH_BIT = 15;
    localparam int LAMP_BIT = 10;
    localparam int SCREEN_BIT = 1;
    localparam int MODE_LSB = 2;
    localparam logic [2:0] DEST_NOP = 3'h0;
    localparam logic [2:0] DEST_LOAD_MODE = 3'h1;
    localparam logic [2:0] DEST_SLIDE = 3'h5;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DIST = 8'h08;
    localparam logic [7:0] OFS_MODE = 8'h0c;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_TXWORD = 8'h14;
    localparam int CTRL_ERR_SW = 0;
    localparam int CTRL_CLR_SW = 1;
    localparam int CTRL_DONE = 2;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;
    localparam int CLK_HZ = 100_000_000;
    localparam int AUTO_RESET_MS = 3000;
    localparam longint AUTO_RESET_CYCLES = longint'(CLK_HZ) / 1000 * AUTO_RESET_MS;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] data;
    } twr_word_type;

    typedef struct packed {
        logic valid;
        logic [OUT_W-1:0] data;
    } twr_tx_type;

endpackage : twr_pkg

// *** twr_shift_in.sv ***
// Purpose: Serial input shift register, assembles 20-bit words
// Assumes: One bit per bit_valid pulse, MSB first
// Notes: Full pulse lasts one cycle
`timescale 1ns/1ps
`default_nettype none
module twr_shift_in #(
    parameter int WIDTH = twr_pkg::WORD_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_clear,
    input wire logic bit_valid,
    input wire logic bit_data,
    output twr_pkg::twr_word_type word_out
);
    logic [WIDTH-1:0] serial_in_shift_reg;
    logic [$clog2(WIDTH+1)-1:0] count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_in_shift_reg <= '0;
            count_reg <= '0;
            word_out <= '0;
        end else begin
            word_out.valid <= 1'b0;
            if (sync_clear) begin
                count_reg <= '0;
            end else if (bit_valid) begin
                serial_in_shift_reg <= {serial_in_shift_reg[WIDTH-2:0], bit_data}; // RL3
                if (count_reg == ($clog2(WIDTH+1))'(WIDTH - 1)) begin
                    count_reg <= '0;
                    word_out.valid <= 1'b1; // RL4
                    word_out.data <= {serial_in_shift_reg[WIDTH-2:0], bit_data};
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

    property p_full_after_bits;
        @(posedge pclk) disable iff (!presetn)
        word_out.valid |-> $past(bit_valid);
    endproperty
    a_full_after_bits: assert property (p_full_after_bits) else $error("word full without a bit"); // RL4
endmodule : twr_shift_in
`default_nettype wire

// *** twr_auto_reset.sv ***
// Purpose: Power-on auto reset generator
// Assumes: presetn marks power application
// Notes: Pulse after the count expires
`timescale 1ns/1ps
`default_nettype none
module twr_auto_reset #(
    parameter longint CYCLES = twr_pkg::AUTO_RESET_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic auto_reset
);
    logic [31:0] count_reg;
    logic done_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            done_reg <= 1'b0;
            auto_reset <= 1'b0;
        end else begin
            auto_reset <= 1'b0;
            if (!done_reg) begin
                if (count_reg == 32'(CYCLES - 1)) begin
                    done_reg <= 1'b1;
                    auto_reset <= 1'b1; // RL15
                end else begin
                    count_reg <= count_reg + 32'h1;
                end
            end
        end
    end

    property p_once;
        @(posedge pclk) disable iff (!presetn)
        auto_reset |=> !auto_reset;
    endproperty
    a_once: assert property (p_once) else $error("auto reset longer than one cycle"); // RL15
endmodule : twr_auto_reset
`default_nettype wire

// *** twr_modem_model.sv ***
// Purpose: Demodulator model feeding serial words to the receiver
// Assumes: Start bit already stripped, words sent MSB first
// Notes: Line toggles between bits so a stale level is never reused
`timescale 1ns/1ps
`default_nettype none
module twr_modem_model (
    input wire logic pclk,
    output logic rx_bit_valid,
    output logic rx_bit
);
    // ----------------------------------------
    // Serial line
    // ----------------------------------------
    logic data_bit = 1'b0;
    logic idle_bit = 1'b0;

    initial rx_bit_valid = 1'b0;
    assign rx_bit = rx_bit_valid ? data_bit : idle_bit;

    always @(posedge pclk) begin
        idle_bit <= ~idle_bit;
    end

    function automatic logic [19:0] frame(input logic [18:0] body, input logic bad);
        return {body, ~^body ^ bad};
    endfunction : frame

    task automatic send(input logic [19:0] w, input int gap);
        for (int i = 19; i >= 0; i--) begin
            // Gaps model the slow remote pace, compressed in time
            for (int g = 0; g < gap; g++) begin
                @(posedge pclk);
                rx_bit_valid <= 1'b0;
            end
            @(posedge pclk);
            rx_bit_valid <= 1'b1;
            data_bit <= w[i];
        end
        @(posedge pclk);
        rx_bit_valid <= 1'b0;
    endtask : send
endmodule : twr_modem_model
`default_nettype wire

// *** terminal_word_receiver_abort_ctl_tb.sv ***
// Purpose: Self-checking bench for the word receiver and abort control
// Assumes: Zero-wait APB, auto reset shortened to 20 cycles
// Notes: Random words come from an LFSR seeded with 7030
`timescale 1ns/1ps
`default_nettype none
module terminal_word_receiver_abort_ctl_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic rx_bit_valid, rx_bit, error_lamp, lamp_on, erase_req, ext_inhibit;
    logic error_switch = 1'b0, clear_switch = 1'b0;
    twr_pkg::twr_word_type ext_word;
    twr_pkg::twr_tx_type tx_word;
    int bad_count = 0, n_compared = 0, ext_cnt = 0, tx_cnt = 0, erase_cnt = 0;
    logic [19:0] last_ext;
    logic [11:0] last_tx;
    logic [15:0] lfsr = 16'h1b76;

    always #5 pclk = ~pclk;

    twr_receiver #(.AUTO_CYCLES(20)) twr_receiver_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .error_switch(error_switch),
        .clear_switch(clear_switch), .error_lamp(error_lamp), .lamp_on(lamp_on), .erase_req(erase_req),
        .ext_inhibit(ext_inhibit), .ext_word(ext_word), .tx_word(tx_word));
    twr_modem_model twr_modem_model_inst (.pclk(pclk), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

    always @(posedge pclk) begin
        if (ext_word.valid === 1'b1) begin
            ext_cnt++;
            last_ext = ext_word.data;
        end
        if (tx_word.valid === 1'b1) begin
            tx_cnt++;
            last_tx = tx_word.data;
        end
        if (erase_req === 1'b1) erase_cnt++;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [18:0] lm(input logic inh, input logic [6:0] c, input logic [4:0] m);
        return {4'h1, inh, 1'b1, c, 1'b0, m};
    endfunction : lm

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        paddr <= {24'h000000, a};
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        if (n == 20) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(name, q, exp);
        check("pslverr", pslverr, 1'b0);
    endtask : rd_chk

    task automatic done();
        logic [31:0] q;
        apb(1'b1, twr_pkg::OFS_CTRL, 32'h1 << twr_pkg::CTRL_DONE, q);
    endtask : done

    task automatic word_in(input logic [18:0] body, input logic bad, input int gap);
        twr_modem_model_inst.send(twr_modem_model_inst.frame(body, bad), gap);
        repeat (4) @(posedge pclk);
    endtask : word_in

    task automatic pulse(input logic clr);
        clear_switch <= clr;
        error_switch <= ~clr;
        @(posedge pclk);
        clear_switch <= 1'b0;
        error_switch <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic [18:0] b;
        int e;
        logic [31:0] q;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        check("auto_erase", erase_cnt, 1);
        check("lamp_rst", lamp_on, 0);
        check("err_rst", error_lamp, 0);
        rd_chk("mode_rst", twr_pkg::OFS_MODE, twr_pkg::MODE_RESET);
        rd_chk("count_rst", twr_pkg::OFS_COUNT, twr_pkg::COUNT_RESET);
        rd_chk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            b = {1'b1, lfsr, lfsr[1:0]};
            word_in(b, 1'b0, lfsr[1:0]);
            check("ext_cnt", ext_cnt, i + 1);
            check("ext_data", last_ext, {b, ~^b});
            rd_chk("dist", twr_pkg::OFS_DIST, {b, ~^b});
            done();
        end
        rd_chk("count", twr_pkg::OFS_COUNT, 32'h8);
        // Second word lands while the first is still being processed
        word_in(19'h40001, 1'b0, 0);
        word_in(19'h7fffe, 1'b0, 0);
        check("held_stays", ext_cnt, 9);
        rd_chk("held_dist", twr_pkg::OFS_DIST, {19'h40001, ~^19'h40001});
        done();
        repeat (4) @(posedge pclk);
        check("held_moves", ext_cnt, 10);
        rd_chk("next_dist", twr_pkg::OFS_DIST, {19'h7fffe, ~^19'h7fffe});
        done();
        word_in(lm(1'b1, 7'h55, 5'h1f), 1'b0, 1);
        done();
        rd_chk("mode_load", twr_pkg::OFS_MODE, 32'hf);
        rd_chk("count_load", twr_pkg::OFS_COUNT, 32'h55);
        check("inhibit", ext_inhibit, 1);
        check("screen_erase", erase_cnt, 2);
        word_in({1'b1, 18'h2aaaa}, 1'b1, 0);
        check("tx_pulse", tx_cnt, 1);
        check("tx_count", last_tx[6:0], 7'h55);
        check("err_on", error_lamp, 1);
        word_in({4'h5, 15'h0200}, 1'b0, 0);
        check("abort_lamp_off", lamp_on, 0);
        pulse(1'b0);
        check("errsw_clear", error_lamp, 0);
        rd_chk("errsw_mode", twr_pkg::OFS_MODE, 32'hf);
        word_in({4'h5, 15'h0200}, 1'b0, 0);
        done();
        check("lamp_set", lamp_on, 1);
        word_in({1'b1, 18'h15555}, 1'b1, 2);
        e = ext_cnt;
        word_in({1'b1, 18'h00f0f}, 1'b0, 0);
        check("abort_drop", ext_cnt, e);
        check("abort_hold", error_lamp, 1);
        word_in(lm(1'b0, 7'h11, 5'h00), 1'b0, 0);
        done();
        check("lm_clear", error_lamp, 0);
        rd_chk("lm_mode_kept", twr_pkg::OFS_MODE, 32'hf);
        rd_chk("lm_count", twr_pkg::OFS_COUNT, 32'h11);
        word_in({1'b1, 18'h3c3c3}, 1'b1, 1);
        check("err_again", error_lamp, 1);
        pulse(1'b1);
        check("clr_abort", error_lamp, 0);
        check("clr_lamp", lamp_on, 0);
        check("clr_erase", erase_cnt, 3);
        rd_chk("clr_mode", twr_pkg::OFS_MODE, twr_pkg::MODE_RESET);
        // Mode field above the screen bit, screen bit clear
        word_in(lm(1'b0, 7'h22, 5'h0a), 1'b0, 0);
        done();
        rd_chk("mode_field", twr_pkg::OFS_MODE, 32'h5);
        check("no_screen", erase_cnt, 3);
        word_in({1'b1, 18'h0f0f0}, 1'b1, 0);
        rd_chk("status_abort", twr_pkg::OFS_STATUS, 32'h1);
        rd_chk("tx_reg", twr_pkg::OFS_TXWORD, 32'h22);
        apb(1'b1, twr_pkg::OFS_CTRL, 32'h1 << twr_pkg::CTRL_ERR_SW, q);
        repeat (2) @(posedge pclk);
        check("sw_err_clear", error_lamp, 0);
        apb(1'b1, twr_pkg::OFS_CTRL, 32'h1 << twr_pkg::CTRL_CLR_SW, q);
        repeat (2) @(posedge pclk);
        check("sw_clr_erase", erase_cnt, 4);
        rd_chk("sw_clr_count", twr_pkg::OFS_COUNT, twr_pkg::COUNT_RESET);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule : terminal_word_receiver_abort_ctl_tb
`default_nettype wire
